// >>> common/scd_cfg.svh
// Constants of the speech command decoder: field positions, reset values, timing
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH
`define SCD_CLK_NS    8
`define SCD_UNIT_NS   16384000
`define SCD_OPT_RST   3'h0
`define SCD_CMD_RST   7'h60
`define SCD_LVL_MIN   2'h3
`define SCD_RPT_INF   2'h3
`define SCD_RPT_ONE   2'h0
`define SCD_RPT_TWO   2'h1
`define SCD_B_PATH    3
`define SCD_B_STBY    2
`define SCD_B_AMP     0
`define SCD_B_FADE    4
`define SCD_B_SD      6
`define SCD_B_SCK     5
`define SCD_P_STB     7
`define SCD_P_CMD     8
`define SCD_P_CH      9
`define SCD_PIN_W     10
`define SCD_REG_CTRL  4'h0
`define SCD_REG_STAT  4'h4
`define SCD_CTRL_SER  0
`define SCD_CTRL_EDIT 1
`define SCD_SER_BITS  4'h8
`endif

// >>> common/scd_pkg.sv
// Types shared by the speech command decoder modules
`include "scd_cfg.svh"
package scd_pkg;
  typedef enum logic [1:0] {
    SCD_K_OPT  = 2'b00,
    SCD_K_SIL  = 2'b01,
    SCD_K_BEEP = 2'b10,
    SCD_K_SPCH = 2'b11
  } scd_kind_e;

  typedef enum logic [1:0] {
    SCD_PB_IDLE = 2'b00,
    SCD_PB_PLAY = 2'b01,
    SCD_PB_SIL  = 2'b10,
    SCD_PB_BEEP = 2'b11
  } scd_pb_e;

  typedef struct packed {
    logic output_path_sel;
    logic standby_conv_sel;
    logic amplitude_sel;
  } scd_opt_s;

  typedef struct packed {
    logic       valid;
    logic       is_cmd;
    logic [6:0] word;
  } scd_word_s;

  typedef struct packed {
    logic       sck_d;
    logic       stb_d;
    logic [7:0] shift;
    logic [3:0] cnt;
    scd_word_s  out;
  } scd_srx_s;

  typedef struct packed {
    logic       start;
    logic       stop;
    logic       chan;
    logic [6:0] addr;
    logic [1:0] lvl;
  } scd_play_s;

  typedef struct packed {
    logic [`SCD_PIN_W-1:0] s1;
    logic [`SCD_PIN_W-1:0] s2;
    logic [`SCD_PIN_W-1:0] s3;
    logic [`SCD_PIN_W-1:0] pin;
    logic                  stb_d;
    logic                  cmd_lat;
    scd_opt_s              opt;
    logic [6:0]            cmd;
    logic                  cmd_ch;
    logic                  port_hi;
    logic                  port_lo;
    scd_pb_e               pb;
    logic                  act_ch;
    logic [6:0]            tmr;
    logic [2:0]            rpt_left;
    logic                  rpt_inf;
    logic                  fade;
    scd_play_s             play;
    logic                  serial_en;
    logic                  edit_en;
    logic                  ack;
    logic [31:0]           rdata;
  } scd_core_s;
endpackage

// >>> core/scd_tick_gen.sv
// Time unit divider: one-cycle tick per silence or beep time unit
`timescale 1ns/10ps
module scd_tick_gen #(
  parameter int UNIT_CYC = 2048000
) (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic run_i,
  input  wire logic restart_i,
  output logic      tick_o
);
  import scd_pkg::*;

  localparam int CW = $clog2(UNIT_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(UNIT_CYC - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } scd_tick_s;

  scd_tick_s r_reg;
  scd_tick_s r_next;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  // Restart aligns the first unit with the load, so a length N lasts N full units
  always_comb begin
    r_next      = r_reg;
    r_next.tick = 1'b0;
    if (restart_i || !run_i) begin
      r_next.cnt = '0;
    end else if (r_reg.cnt == LAST) begin
      r_next.cnt  = '0;
      r_next.tick = 1'b1;
    end else begin
      r_next.cnt = r_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick_o = r_reg.tick;
endmodule

// >>> core/scd_serial_rx.sv
// Serial word receiver: type flag plus seven word bits, closed by strobe rise
`timescale 1ns/10ps
`include "scd_cfg.svh"
module scd_serial_rx (
  input  wire logic         core_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         enable_i,
  input  wire logic         sck_i,
  input  wire logic         sd_i,
  input  wire logic         stb_n_i,
  output scd_pkg::scd_word_s word_o
);
  import scd_pkg::*;

  scd_srx_s r_reg;
  scd_srx_s r_next;

  // ----------------------------------------
  // Shifter
  // ----------------------------------------
  // Inputs are already filtered, so edges here are clean
  always_comb begin
    r_next           = r_reg;
    r_next.sck_d     = sck_i;
    r_next.stb_d     = stb_n_i;
    r_next.out.valid = 1'b0;
    if (enable_i && sck_i && !r_reg.sck_d) begin
      r_next.shift = {r_reg.shift[6:0], sd_i};
      if (r_reg.cnt != 4'hF) begin
        r_next.cnt = r_reg.cnt + 4'h1;
      end
    end
    if (enable_i && stb_n_i && !r_reg.stb_d) begin
      r_next.cnt = 4'h0;
      // Short frames are dropped; long ones keep the last eight bits
      if (r_reg.cnt >= `SCD_SER_BITS) begin
        r_next.out.valid  = 1'b1;
        r_next.out.is_cmd = r_reg.shift[7];
        r_next.out.word   = r_reg.shift[6:0];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      // Edge memories start at the synchronised pin level, so no false edge follows reset
      r_reg       <= '0;
      r_reg.sck_d <= 1'b1;
      r_reg.stb_d <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign word_o = r_reg.out;
endmodule

// >>> core/scd_core.sv
// Command and address decoder of a two-channel speech playback device
// Behaviour
// - Power-up options: filtered output, standby conversion on, full swing.
// - Reset low returns all options to power-up defaults; here sys_rst_i resets on high.
// - Option bits: I3 output path, I2 standby conversion, I0 amplitude.
// - Top bits decode: 000 option, 01x silence, 100 beep, 11 speech.
// - Stored command word starts as speech control with zero parameters.
// - Options stay unchanged until the next option command, power off or reset.
// - Serial first bit high means command word, low means address.
// - Silence length is address value times 16.384 ms, at most 127.
// - Silence ignores I4, I1, I0; channel taken at command write.
// - Serial mode ports follow silence I3, I2; low after reset.
// - Beep I3..I2 set amplitude: eighth, quarter, third, half.
// - Beep I1..I0 set tone: 0.5, 1.0, 1.6, 2.0 kHz.
// - Beep duration is next address value times 16.384 ms.
// - One speech control setting shared by both channels, kept.
// - Speech I3..I2 repeat count: once, twice, four, endless.
// - Fade halves volume per repeat, floor one eighth.
// - Edit table in use: channel one command writes are ignored.
// - Speech I1..I0 attenuation: none, -6, -12, -18 dB.
// - All-zero address during playback stops and mutes to mid-supply.
// - Address after port command without speech command is silence length.
// - Parallel command only when command select low during strobe low.
`timescale 1ns/10ps
`include "scd_cfg.svh"
module scd_core #(
  parameter int UNIT_CYC = `SCD_UNIT_NS / `SCD_CLK_NS
) (
  input  wire logic          core_clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic [6:0]    word_i,
  input  wire logic          start_strobe_n_i,
  input  wire logic          cmd_sel_n_i,
  input  wire logic          channel_select_i,
  input  wire logic          phrase_end_i,
  output logic               host_port_out_hi_o,
  output logic               host_port_out_hi_oe_o,
  output logic               host_port_out_lo_o,
  output logic               host_port_out_lo_oe_o,
  output logic               next_address_request_o,
  output logic               speaking_n_o,
  output scd_pkg::scd_opt_s  options_o,
  output scd_pkg::scd_play_s play_o,
  output logic               silence_on_o,
  output logic               beep_on_o,
  output logic [1:0]         beep_level_o,
  output logic [1:0]         beep_freq_o,
  input  wire logic [3:0]    avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [31:0]   avs_writedata_i,
  input  wire logic [3:0]    avs_byteenable_i,
  output logic [31:0]        avs_readdata_o,
  output logic               avs_waitrequest_o
);
  import scd_pkg::*;

  scd_core_s r_reg;
  scd_core_s r_next;
  scd_word_s srx_word;
  scd_word_s ev;
  scd_kind_e kind;
  logic      kind_ok;
  logic      blocked;
  logic      tick;
  logic      tmr_load;
  logic      bus_req;
  logic      stb_rise;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  scd_serial_rx u_srx (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .enable_i   (r_reg.serial_en),
    .sck_i      (r_reg.pin[`SCD_B_SCK]),
    .sd_i       (r_reg.pin[`SCD_B_SD]),
    .stb_n_i    (r_reg.pin[`SCD_P_STB]),
    .word_o     (srx_word)
  );

  scd_tick_gen #(
    .UNIT_CYC (UNIT_CYC)
  ) u_tick (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .run_i      (r_reg.pb == SCD_PB_SIL || r_reg.pb == SCD_PB_BEEP),
    .restart_i  (tmr_load),
    .tick_o     (tick)
  );

  // ----------------------------------------
  // Word source
  // ----------------------------------------
  // Parallel words are taken at strobe rise, kind fixed while strobe was low
  assign stb_rise = r_reg.pin[`SCD_P_STB] && !r_reg.stb_d;

  always_comb begin
    if (r_reg.serial_en) begin
      ev = srx_word;
    end else begin
      ev.valid  = stb_rise;
      ev.is_cmd = r_reg.cmd_lat;
      ev.word   = r_reg.pin[6:0];
    end
  end

  assign kind    = scd_kind_e'(ev.word[6:5]);
  assign kind_ok = ev.word[5] || !ev.word[4];
  assign blocked = r_reg.edit_en && r_reg.pin[`SCD_P_CH];
  assign tmr_load = ev.valid && !ev.is_cmd && ev.word != 7'h00
                    && (r_reg.cmd[6:5] == SCD_K_SIL || r_reg.cmd[6:5] == SCD_K_BEEP);
  assign bus_req = avs_read_i || avs_write_i;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    r_next            = r_reg;
    r_next.s1         = {channel_select_i, cmd_sel_n_i, start_strobe_n_i, word_i};
    r_next.s2         = r_reg.s1;
    r_next.s3         = r_reg.s2;
    // A pin changes once the second and third stages agree
    r_next.pin        = (r_reg.s2 & r_reg.s3) | (r_reg.pin & (r_reg.s2 | r_reg.s3));
    r_next.stb_d      = r_reg.pin[`SCD_P_STB];
    r_next.play.start = 1'b0;
    r_next.play.stop  = 1'b0;
    if (!r_reg.pin[`SCD_P_STB] && !r_reg.pin[`SCD_P_CMD]) begin
      r_next.cmd_lat = 1'b1;
    end else if (stb_rise) begin
      r_next.cmd_lat = 1'b0;
    end

    // Commands
    if (ev.valid && ev.is_cmd && !blocked && kind_ok) begin
      r_next.cmd = ev.word;
      case (kind)
        SCD_K_OPT: begin
          r_next.opt.output_path_sel  = ev.word[`SCD_B_PATH];
          r_next.opt.standby_conv_sel = ev.word[`SCD_B_STBY];
          r_next.opt.amplitude_sel    = ev.word[`SCD_B_AMP];
        end
        SCD_K_SIL: begin
          r_next.cmd_ch = r_reg.pin[`SCD_P_CH];
          if (r_reg.serial_en) begin
            r_next.port_hi = ev.word[3];
            r_next.port_lo = ev.word[2];
          end
        end
        default: begin
          r_next.cmd_ch = r_reg.pin[`SCD_P_CH];
        end
      endcase
    end

    // Addresses
    if (ev.valid && !ev.is_cmd) begin
      if (ev.word == 7'h00) begin
        if (r_reg.pb != SCD_PB_IDLE) begin
          r_next.pb        = SCD_PB_IDLE;
          r_next.play.stop = 1'b1;
          r_next.tmr       = 7'h00;
        end
      end else begin
        case (scd_kind_e'(r_reg.cmd[6:5]))
          SCD_K_SIL: begin
            r_next.pb     = SCD_PB_SIL;
            r_next.tmr    = ev.word;
            r_next.act_ch = r_reg.cmd_ch;
          end
          SCD_K_BEEP: begin
            r_next.pb     = SCD_PB_BEEP;
            r_next.tmr    = ev.word;
            r_next.act_ch = r_reg.cmd_ch;
          end
          SCD_K_SPCH: begin
            r_next.pb         = SCD_PB_PLAY;
            r_next.act_ch     = r_reg.pin[`SCD_P_CH];
            r_next.play.start = 1'b1;
            r_next.play.chan  = r_reg.pin[`SCD_P_CH];
            r_next.play.addr  = ev.word;
            r_next.play.lvl   = r_reg.cmd[1:0];
            r_next.fade       = r_reg.cmd[`SCD_B_FADE];
            r_next.rpt_inf    = r_reg.cmd[3:2] == `SCD_RPT_INF;
            case (r_reg.cmd[3:2])
              `SCD_RPT_ONE: r_next.rpt_left = 3'h1;
              `SCD_RPT_TWO: r_next.rpt_left = 3'h2;
              default:      r_next.rpt_left = 3'h4;
            endcase
          end
          default: begin
            // Address right after an option command starts nothing
            r_next.pb = r_reg.pb;
          end
        endcase
      end
    end else if (tick && (r_reg.pb == SCD_PB_SIL || r_reg.pb == SCD_PB_BEEP)) begin
      r_next.tmr = r_reg.tmr - 7'h1;
      if (r_reg.tmr <= 7'h1) begin
        r_next.pb = SCD_PB_IDLE;
      end
    end else if (phrase_end_i && r_reg.pb == SCD_PB_PLAY) begin
      if (r_reg.rpt_inf || r_reg.rpt_left > 3'h1) begin
        r_next.play.start = 1'b1;
        if (!r_reg.rpt_inf) begin
          r_next.rpt_left = r_reg.rpt_left - 3'h1;
        end
        if (r_reg.fade && r_reg.play.lvl != `SCD_LVL_MIN) begin
          r_next.play.lvl = r_reg.play.lvl + 2'h1;
        end
      end else begin
        r_next.pb = SCD_PB_IDLE;
      end
    end

    // Register slave, one wait cycle per access
    r_next.ack = bus_req && !r_reg.ack;
    if (bus_req && !r_reg.ack) begin
      case (avs_address_i)
        `SCD_REG_CTRL: r_next.rdata = {30'h0, r_reg.edit_en, r_reg.serial_en};
        `SCD_REG_STAT: r_next.rdata = {16'h0, r_reg.play.lvl, r_reg.pb, r_reg.port_hi,
                                       r_reg.port_lo, r_reg.cmd, r_reg.opt};
        default:       r_next.rdata = 32'h0;
      endcase
    end
    if (avs_write_i && r_reg.ack && avs_address_i == `SCD_REG_CTRL && avs_byteenable_i[0]) begin
      r_next.serial_en = avs_writedata_i[`SCD_CTRL_SER];
      r_next.edit_en   = avs_writedata_i[`SCD_CTRL_EDIT];
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      r_reg          <= '0;
      r_reg.s1       <= '1;
      r_reg.s2       <= '1;
      r_reg.s3       <= '1;
      r_reg.pin      <= '1;
      r_reg.stb_d    <= 1'b1;
      r_reg.opt      <= `SCD_OPT_RST;
      r_reg.cmd      <= `SCD_CMD_RST;
      r_reg.port_hi  <= 1'b0;
      r_reg.port_lo  <= 1'b0;
      r_reg.pb       <= SCD_PB_IDLE;
      r_reg.rpt_left <= 3'h1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign host_port_out_hi_o     = r_reg.port_hi;
  assign host_port_out_lo_o     = r_reg.port_lo;
  assign host_port_out_hi_oe_o  = r_reg.serial_en;
  assign host_port_out_lo_oe_o  = r_reg.serial_en;
  assign next_address_request_o = !(r_reg.pb != SCD_PB_IDLE
                                    && r_reg.act_ch == r_reg.pin[`SCD_P_CH]);
  assign speaking_n_o           = r_reg.pb == SCD_PB_IDLE;
  assign options_o              = r_reg.opt;
  assign play_o                 = r_reg.play;
  assign silence_on_o           = r_reg.pb == SCD_PB_SIL;
  assign beep_on_o              = r_reg.pb == SCD_PB_BEEP;
  assign beep_level_o           = r_reg.cmd[3:2];
  assign beep_freq_o            = r_reg.cmd[1:0];
  assign avs_readdata_o         = r_reg.rdata;
  assign avs_waitrequest_o      = bus_req && !r_reg.ack;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_reset_defaults: assert property (
    disable iff (1'b0) $past(sys_rst_i) |-> (r_reg.opt == `SCD_OPT_RST
      && r_reg.cmd == `SCD_CMD_RST && !r_reg.port_hi && !r_reg.port_lo))
    else $error("defaults not restored by reset");

  a_opt_decode: assert property (
    (ev.valid && ev.is_cmd && !blocked && ev.word[6:4] == 3'h0)
    |=> options_o == {$past(ev.word[3]), $past(ev.word[2]), $past(ev.word[0])})
    else $error("option bits not taken from command");

  a_opt_hold: assert property (
    !(ev.valid && ev.is_cmd && !blocked && ev.word[6:4] == 3'h0) |=> $stable(r_reg.opt))
    else $error("option changed without option command");

  a_stop_code: assert property (
    (ev.valid && !ev.is_cmd && ev.word == 7'h00 && r_reg.pb != SCD_PB_IDLE)
    |=> (speaking_n_o && play_o.stop) ##1 !play_o.stop)
    else $error("stop code did not end playback");

  a_port_follow: assert property (
    (r_reg.serial_en && ev.valid && ev.is_cmd && !blocked && ev.word[6:5] == 2'b01)
    |=> host_port_out_hi_o == $past(ev.word[3]) && host_port_out_lo_o == $past(ev.word[2]))
    else $error("port pins do not follow silence command");

  a_edit_block: assert property (
    (ev.valid && ev.is_cmd && blocked) |=> $stable(r_reg.cmd) && $stable(r_reg.opt))
    else $error("channel one command taken while edit table in use");

  a_silence_len: assert property (
    (ev.valid && !ev.is_cmd && ev.word != 7'h00 && r_reg.cmd[6:5] == 2'b01)
    |=> silence_on_o && r_reg.tmr == $past(ev.word))
    else $error("silence length not loaded");

  a_unit_step: assert property (
    (tick && silence_on_o && !ev.valid && r_reg.tmr > 7'h1)
    |=> r_reg.tmr == $past(r_reg.tmr) - 7'h1 && silence_on_o)
    else $error("silence timer did not step on unit tick");

  a_fade_floor: assert property (
    (r_reg.pb == SCD_PB_PLAY && phrase_end_i && !ev.valid && r_reg.fade
     && r_reg.play.lvl == `SCD_LVL_MIN && r_reg.rpt_inf)
    |=> play_o.start && play_o.lvl == `SCD_LVL_MIN)
    else $error("fade went below one eighth");

  a_repeat_once: assert property (
    (r_reg.pb == SCD_PB_PLAY && phrase_end_i && !ev.valid && !r_reg.rpt_inf
     && r_reg.rpt_left == 3'h1) |=> speaking_n_o && !play_o.start)
    else $error("playback repeated past its count");
endmodule

// >>> test/scd_host_model.sv
// Host model driving the decoder's parallel and serial pins
`timescale 1ns/10ps
module scd_host_model (
  input  wire logic core_clk_i,
  output logic [6:0] word_o,
  output logic       stb_n_o,
  output logic       cmd_n_o,
  output logic       ch_o
);
  initial begin
    word_o = 7'h00;
    stb_n_o = 1'b1;
    cmd_n_o = 1'b1;
    ch_o = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // Every level held past the 4-cycle pin filter
  task automatic strobe();
    cyc(2);
    stb_n_o <= 1'b0;
    cyc(6);
    stb_n_o <= 1'b1;
    cyc(10);
  endtask
  task automatic put(input logic [6:0] w, input logic c, input logic ch);
    @(posedge core_clk_i);
    word_o <= w;
    cmd_n_o <= ~c;
    ch_o <= ch;
    strobe();
    cmd_n_o <= 1'b1;
  endtask
  // Link clock of 125 ns, free of the core clock, held low between frames
  task automatic sput(input logic [6:0] w, input logic c);
    logic [7:0] f;
    f = {c, w};
    @(posedge core_clk_i);
    for (int i = 7; i >= 0; i--) begin
      word_o <= {f[i], 6'h00};
      #62.5;
      word_o[5] <= 1'b1;
      #62.5;
    end
    word_o <= {~f[0], 6'h00};
    strobe();
  endtask
endmodule

// >>> test/testbench.sv
// Self-checking bench of the speech command decoder
`timescale 1ns/10ps
module testbench;
  import scd_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        phrase_end_i = 1'b0;
  logic [6:0]  host_w;
  logic        stb_n;
  logic        cmd_n;
  logic        ch;
  wire  [6:0]  word;
  logic        hi, hi_oe, lo, lo_oe, spk_n, sil_on, beep_on, next_address_request;
  logic [1:0]  b_lvl, b_frq, last_lvl;
  logic [6:0]  last_addr;
  scd_opt_s    opt;
  scd_play_s   play;
  logic [3:0]  a_addr = 4'h0;
  logic        a_rd = 1'b0;
  logic        a_wr = 1'b0;
  logic [31:0] a_wd = 32'h0;
  logic [31:0] a_rdata;
  logic        a_wait;
  logic [31:0] expq[$];
  int          err_count = 0;
  int          tests_run = 0;
  int          seed = 32'h7EFF5C14;
  int          starts = 0;
  int          stops = 0;
  // Port pins win the shared wires while their enables are high
  assign word = {host_w[6:4], hi_oe ? hi : host_w[3], lo_oe ? lo : host_w[2], host_w[1:0]};
  always #4 core_clk_i = ~core_clk_i;
  scd_host_model host_i (.core_clk_i(core_clk_i), .word_o(host_w), .stb_n_o(stb_n),
    .cmd_n_o(cmd_n), .ch_o(ch));
  scd_core #(.UNIT_CYC(8)) scd_core_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .word_i(word), .start_strobe_n_i(stb_n), .cmd_sel_n_i(cmd_n), .channel_select_i(ch),
    .phrase_end_i(phrase_end_i), .host_port_out_hi_o(hi), .host_port_out_hi_oe_o(hi_oe),
    .host_port_out_lo_o(lo), .host_port_out_lo_oe_o(lo_oe), .next_address_request_o(next_address_request),
    .speaking_n_o(spk_n), .options_o(opt), .play_o(play), .silence_on_o(sil_on),
    .beep_on_o(beep_on), .beep_level_o(b_lvl), .beep_freq_o(b_frq), .avs_address_i(a_addr),
    .avs_read_i(a_rd), .avs_write_i(a_wr), .avs_writedata_i(a_wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(a_rdata), .avs_waitrequest_o(a_wait));
  // ---------------------------------------------
  // Shared tasks and watchers
  // ---------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    a_addr <= a;
    a_wd <= d;
    a_rd <= ~w;
    a_wr <= w;
    // Waitrequest is looked at on the rising edge; the request drops at that same edge
    do begin
      @(posedge core_clk_i);
      n++;
    end while (a_wait !== 1'b0 && n < 50);
    a_rd <= 1'b0;
    a_wr <= 1'b0;
    if (a_wait !== 1'b0) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic rst();
    @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    repeat (12) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask
  always @(posedge core_clk_i) begin
    if (a_rd === 1'b1 && a_wait === 1'b0 && expq.size() > 0) check(a_rdata, expq.pop_front());
  end
  always @(negedge core_clk_i) begin
    if (play.start === 1'b1) begin
      starts++;
      last_lvl = play.lvl;
      last_addr = play.addr;
    end
    if (play.stop === 1'b1) stops++;
  end
  initial begin
    repeat (100000) @(posedge core_clk_i);
    err_count++;
    end_of_test();
  end
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    logic [6:0] a;
    logic [2:0] o;
    rst();
    wt(0);
    check({opt, hi, lo, hi_oe, lo_oe}, 7'h00);
    rd(4'h4, {16'h0, 2'h0, 2'h0, 2'h0, 7'h60, 3'h0});
    rd(4'h8, 32'h0);
    bus(1'b1, 4'hC, 32'hFFFF_FFFF);
    rd(4'h0, 32'h0);
    for (int i = 0; i < 8; i++) begin
      o = i[2:0];
      host_i.put({3'b000, o[2], o[1], 1'b0, o[0]}, 1'b1, 1'b1);
      host_i.put(7'h05, 1'b0, 1'b1);
      wt(0);
      check({opt, spk_n}, {o, 1'b1});
    end
    rst();
    wt(0);
    check(opt, 3'h0);
    host_i.put(7'h33, 1'b1, 1'b0);
    host_i.put(7'h03, 1'b0, 1'b0);
    wt(12);
    check({sil_on, next_address_request}, 2'b10);
    wt(20);
    check({sil_on, next_address_request}, 2'b01);
    for (int i = 0; i < 16; i++) begin
      host_i.put({3'b100, i[3:0]}, 1'b1, 1'b1);
      wt(0);
      check({b_lvl, b_frq}, i[3:0]);
    end
    host_i.put(7'h02, 1'b0, 1'b1);
    wt(0);
    check(beep_on, 1'b1);
    wt(30);
    check(beep_on, 1'b0);
    for (int r = 0; r < 4; r++) begin
      a = 7'($random(seed)) | 7'h01;
      host_i.put({3'b111, r[1:0], 2'h2}, 1'b1, 1'b1);
      starts = 0;
      host_i.put(a, 1'b0, 1'b1);
      for (int k = 0; k < 7; k++) begin
        @(posedge core_clk_i);
        phrase_end_i <= 1'b1;
        @(posedge core_clk_i);
        phrase_end_i <= 1'b0;
        wt(4);
      end
      check({starts[3:0], last_lvl, last_addr}, {4'(1 << r), r == 0 ? 2'h2 : 2'h3, a});
    end
    check(spk_n, 1'b0);
    host_i.put(7'h00, 1'b0, 1'b1);
    wt(0);
    check({stops[1:0], spk_n}, 3'b011);
    starts = 0;
    host_i.put(a, 1'b0, 1'b0);
    wt(0);
    check({starts[1:0], play.chan, last_lvl}, 5'b01010);
    host_i.put(7'h00, 1'b0, 1'b0);
    host_i.put(7'h00, 1'b0, 1'b0);
    wt(0);
    check({stops[1:0], spk_n}, 3'b101);
    bus(1'b1, 4'h0, 32'h2);
    host_i.put(7'h45, 1'b1, 1'b1);
    wt(0);
    check({b_lvl, b_frq}, 4'hE);
    host_i.put(7'h45, 1'b1, 1'b0);
    bus(1'b1, 4'h0, 32'h0);
    host_i.put(7'h4A, 1'b0, 1'b1);
    wt(0);
    check({b_lvl, b_frq, beep_on}, 5'h0B);
    host_i.put(7'h00, 1'b0, 1'b1);
    bus(1'b1, 4'h0, 32'h1);
    rd(4'h0, 32'h1);
    host_i.sput(7'h28, 1'b1);
    wt(0);
    check({hi_oe, lo_oe, hi, lo}, 4'hE);
    host_i.sput(7'h02, 1'b0);
    wt(0);
    check(sil_on, 1'b1);
    host_i.sput(7'h60, 1'b1);
    host_i.sput(7'h24, 1'b1);
    wt(0);
    check({hi, lo}, 2'b01);
    rst();
    wt(0);
    check({hi, lo, hi_oe, lo_oe, opt}, 7'h00);
    end_of_test();
  end
endmodule
